// *** hdl/hrc_pkg.sv ***
// Constants, types and carriers for the hibernation power controller
package hrc_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_COUNTER = 12'h000;
   localparam logic [11:0] OFS_MATCH_ZERO = 12'h004;
   localparam logic [11:0] OFS_MATCH_ONE = 12'h008;
   localparam logic [11:0] OFS_LOAD = 12'h00C;
   localparam logic [11:0] OFS_CONTROL = 12'h010;
   localparam logic [11:0] OFS_MASK = 12'h014;
   localparam logic [11:0] OFS_RAW = 12'h018;
   localparam logic [11:0] OFS_MASKED = 12'h01C;
   localparam logic [11:0] OFS_CLEAR = 12'h020;
   localparam logic [11:0] OFS_TRIM = 12'h024;
   localparam logic [11:0] OFS_DATA_FIRST = 12'h030;
   localparam logic [11:0] OFS_DATA_LAST = 12'h12C;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_MATCH = 32'hFFFF_FFFF;
   localparam logic [31:0] RST_LOAD = 32'hFFFF_FFFF;
   localparam logic [31:0] RST_COUNTER = 32'h0000_0000;
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [3:0] RST_EVENTS = 4'h0;
   localparam logic [15:0] TRIM_NOMINAL = 16'h7FFF;
   localparam logic [31:0] RST_DATA = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Control bit positions
   // ----------------------------------------------------------------
   localparam int unsigned CTL_COUNTER_ENABLE = 0;
   localparam int unsigned CTL_HIBERNATE_REQUEST = 1;
   localparam int unsigned CTL_CLOCK_SOURCE_SELECT = 2;
   localparam int unsigned CTL_MATCH_WAKE_ENABLE = 3;
   localparam int unsigned CTL_PIN_WAKE_ENABLE = 4;
   localparam int unsigned CTL_LOW_BATTERY_ENABLE = 5;
   localparam int unsigned CTL_SLOW_CLOCK_ENABLE = 6;
   localparam int unsigned CTL_POWER_CUT_ABORT = 7;

   // ----------------------------------------------------------------
   // Event bit positions (raw, masked, mask and clear share them)
   // ----------------------------------------------------------------
   localparam int unsigned EVT_MATCH_ZERO = 0;
   localparam int unsigned EVT_MATCH_ONE = 1;
   localparam int unsigned EVT_LOW_BATTERY = 2;
   localparam int unsigned EVT_WAKE_PIN = 3;

   // ----------------------------------------------------------------
   // Counts
   // ----------------------------------------------------------------
   localparam logic [6:0] XTAL_DIV_LAST = 7'h7F;
   localparam logic [5:0] TRIM_SECOND = 6'h00;
   localparam int unsigned DATA_WORDS = 64;

   // ----------------------------------------------------------------
   // Pin synchroniser lanes
   // ----------------------------------------------------------------
   localparam int unsigned PIN_COUNT = 4;
   localparam int unsigned PIN_OSC = 0;
   localparam int unsigned PIN_XTAL = 1;
   localparam int unsigned PIN_WAKE_N = 2;
   localparam int unsigned PIN_LOW_BATTERY = 3;
   localparam logic [3:0] PIN_RESET = 4'h4;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {
      HRC_ST_RUN = 1'b0,
      HRC_ST_HIB = 1'b1
   } hrc_state_t;

   typedef struct packed {
      logic [11:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [11:0] araddr;
      logic arvalid;
      logic rready;
   } hrc_axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } hrc_axil_rsp_t;

endpackage

// *** hdl/hrc_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter, one lane per pin
`timescale 1ns/1ps
`default_nettype none
module hrc_pin_sync (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pins and filtered levels
   input wire logic [hrc_pkg::PIN_COUNT-1:0] pin_in,
   output logic [hrc_pkg::PIN_COUNT-1:0] level_q
);
   logic [hrc_pkg::PIN_COUNT-1:0] ff1_q;
   logic [hrc_pkg::PIN_COUNT-1:0] ff2_q;
   logic [hrc_pkg::PIN_COUNT-1:0] ff3_q;

   genvar g;
   generate
      for (g = 0; g < hrc_pkg::PIN_COUNT; g++) begin : lane
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               ff1_q[g] <= hrc_pkg::PIN_RESET[g];
               ff2_q[g] <= hrc_pkg::PIN_RESET[g];
               ff3_q[g] <= hrc_pkg::PIN_RESET[g];
               level_q[g] <= hrc_pkg::PIN_RESET[g];
            end else begin
               ff1_q[g] <= pin_in[g];
               ff2_q[g] <= ff1_q[g];
               ff3_q[g] <= ff2_q[g];
               // Change only once stages two and three agree
               if (ff2_q[g] == ff3_q[g]) begin
                  level_q[g] <= ff3_q[g];
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// *** hdl/hrc_controller.sv ***
// Hibernation power controller: seconds counter, matches, events, power cut
//
// Behaviour
// - Low battery below threshold; not measured hibernating
// - Low battery sets raw flag when enabled
// - Low battery, when enabled, with abort refuses hibernation
// - Thirty-two bit seconds counter, one per second
// - Predivider counts slow ticks; trim resets 0x7FFF
// - Trim used one second in sixty-four
// - Larger trim slows, smaller trim speeds
// - Two match registers wake or interrupt
// - Counter advances only with counter enable
// - Load write sets counter any time
// - Sixty-four retained read/write words
// - Hibernate request asserts regulator off output
// - Wake on pin or match when enabled
// - Wake releases regulator; raw keeps wake event
// - Pin, match, battery events ORed to interrupt
// - Raw, masked status; write one clears
// - Control bit two picks oscillator or crystal
// - Mask bits one and zero enable matches
`timescale 1ns/1ps
`default_nettype none
module hrc_controller (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire hrc_pkg::hrc_axil_req_t axi_req,
   output hrc_pkg::hrc_axil_rsp_t axi_rsp,
   // Slow clock pins
   input wire logic osc_32k_in,
   input wire logic xtal_in,
   // Wake pin and battery comparator
   input wire logic wake_n,
   input wire logic low_battery_in,
   // Power and interrupt
   output logic regulator_off_n,
   output logic irq
);

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic [hrc_pkg::PIN_COUNT-1:0] pin_lvl;
   logic [hrc_pkg::PIN_COUNT-1:0] pin_prev_q;

   hrc_pin_sync u_pin_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in({low_battery_in, wake_n, xtal_in, osc_32k_in}),
      .level_q(pin_lvl)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_prev_q <= hrc_pkg::PIN_RESET;
      end else begin
         pin_prev_q <= pin_lvl;
      end
   end

   wire logic osc_rise = pin_lvl[hrc_pkg::PIN_OSC] & ~pin_prev_q[hrc_pkg::PIN_OSC];
   wire logic xtal_rise = pin_lvl[hrc_pkg::PIN_XTAL] & ~pin_prev_q[hrc_pkg::PIN_XTAL];
   wire logic wake_fall = ~pin_lvl[hrc_pkg::PIN_WAKE_N] & pin_prev_q[hrc_pkg::PIN_WAKE_N];
   wire logic wake_low = ~pin_lvl[hrc_pkg::PIN_WAKE_N];
   wire logic battery_low = pin_lvl[hrc_pkg::PIN_LOW_BATTERY];

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [31:0] match0_q;
   logic [31:0] match1_q;
   logic [31:0] load_q;
   logic [31:0] count_q;
   logic [7:0] ctl_q;
   logic [3:0] mask_q;
   logic [3:0] raw_q;
   logic [15:0] trim_q;
   logic [31:0] data_q [hrc_pkg::DATA_WORDS];
   hrc_pkg::hrc_state_t state_q;

   // ----------------------------------------------------------------
   // Bus write channel
   // ----------------------------------------------------------------
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic [11:0] waddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   wire logic aw_take = axi_req.awvalid & awready_q;
   wire logic w_take = axi_req.wvalid & wready_q;
   wire logic wr_fire = ~awready_q & ~wready_q & ~bvalid_q;
   wire logic [11:0] wword = {waddr_q[11:2], 2'b00};

   wire logic [11:0] wdata_off = wword - hrc_pkg::OFS_DATA_FIRST;
   wire logic [5:0] wdata_idx = wdata_off[7:2];
   wire logic wsel_data = (wword >= hrc_pkg::OFS_DATA_FIRST) &&
                          (wword <= hrc_pkg::OFS_DATA_LAST);
   wire logic wsel_m0 = wword == hrc_pkg::OFS_MATCH_ZERO;
   wire logic wsel_m1 = wword == hrc_pkg::OFS_MATCH_ONE;
   wire logic wsel_ld = wword == hrc_pkg::OFS_LOAD;
   wire logic wsel_ctl = wword == hrc_pkg::OFS_CONTROL;
   wire logic wsel_mask = wword == hrc_pkg::OFS_MASK;
   wire logic wsel_clr = wword == hrc_pkg::OFS_CLEAR;
   wire logic wsel_trim = wword == hrc_pkg::OFS_TRIM;
   wire logic wsel_ro = (wword == hrc_pkg::OFS_COUNTER) || (wword == hrc_pkg::OFS_RAW) ||
                        (wword == hrc_pkg::OFS_MASKED);
   wire logic wmapped = wsel_data | wsel_m0 | wsel_m1 | wsel_ld | wsel_ctl | wsel_mask |
                        wsel_clr | wsel_trim | wsel_ro;

   // Byte-lane merge of write data into an existing word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return res;
   endfunction

   wire logic [31:0] ld_merged = merge(load_q, wdata_q, wstrb_q);
   wire logic [31:0] ctl_merged = merge({24'h00_0000, ctl_q}, wdata_q, wstrb_q);
   wire logic [31:0] mask_merged = merge({28'h000_0000, mask_q}, wdata_q, wstrb_q);
   wire logic [31:0] trim_merged = merge({16'h0000, trim_q}, wdata_q, wstrb_q);
   wire logic [31:0] clr_bits = merge(32'h0000_0000, wdata_q, wstrb_q);

   wire logic we_ld = wr_fire & wsel_ld;
   wire logic we_ctl = wr_fire & wsel_ctl;
   wire logic [3:0] clr_mask = (wr_fire & wsel_clr) ? clr_bits[3:0] : 4'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= hrc_pkg::RESP_OKAY;
         waddr_q <= 12'h000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (aw_take) begin
            waddr_q <= axi_req.awaddr;
            awready_q <= 1'b0;
         end
         if (w_take) begin
            wdata_q <= axi_req.wdata;
            wstrb_q <= axi_req.wstrb;
            wready_q <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wmapped ? hrc_pkg::RESP_OKAY : hrc_pkg::RESP_SLVERR;
         end else if (bvalid_q && axi_req.bready) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   wire logic low_battery_flag_en = ctl_q[hrc_pkg::CTL_LOW_BATTERY_ENABLE];
   wire logic abort_now = low_battery_flag_en & ctl_q[hrc_pkg::CTL_POWER_CUT_ABORT] & battery_low;
   wire logic hib_req = ctl_q[hrc_pkg::CTL_HIBERNATE_REQUEST];
   wire logic in_hib = state_q == hrc_pkg::HRC_ST_HIB;
   logic wake_now;
   // Request dropped either by wake or by a refused entry
   wire logic drop_req = (in_hib & wake_now) | (~in_hib & hib_req & abort_now);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         match0_q <= hrc_pkg::RST_MATCH;
         match1_q <= hrc_pkg::RST_MATCH;
         load_q <= hrc_pkg::RST_LOAD;
         ctl_q <= hrc_pkg::RST_CONTROL;
         mask_q <= hrc_pkg::RST_EVENTS;
         trim_q <= hrc_pkg::TRIM_NOMINAL;
      end else begin
         if (wr_fire && wsel_m0) begin
            match0_q <= merge(match0_q, wdata_q, wstrb_q);
         end
         if (wr_fire && wsel_m1) begin
            match1_q <= merge(match1_q, wdata_q, wstrb_q);
         end
         if (we_ld) begin
            load_q <= ld_merged;
         end
         if (we_ctl) begin
            ctl_q <= ctl_merged[7:0];
         end else if (drop_req) begin
            ctl_q[hrc_pkg::CTL_HIBERNATE_REQUEST] <= 1'b0;
         end
         if (wr_fire && wsel_mask) begin
            mask_q <= mask_merged[3:0];
         end
         if (wr_fire && wsel_trim) begin
            trim_q <= trim_merged[15:0];
         end
      end
   end

   // Retained words; no reset path other than the bus reset
   genvar gi;
   generate
      for (gi = 0; gi < hrc_pkg::DATA_WORDS; gi++) begin : word
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               data_q[gi] <= hrc_pkg::RST_DATA;
            end else if (wr_fire && wsel_data && (wdata_idx == 6'(gi))) begin
               data_q[gi] <= merge(data_q[gi], wdata_q, wstrb_q);
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Slow clock source and predivider
   // ----------------------------------------------------------------
   logic [6:0] xdiv_q;
   logic [15:0] prediv_q;
   logic [5:0] sec64_q;
   logic count_moved_q;

   wire logic xtal_tick = xtal_rise & (xdiv_q == hrc_pkg::XTAL_DIV_LAST);
   wire logic slow_tick = ctl_q[hrc_pkg::CTL_SLOW_CLOCK_ENABLE] &
                          (ctl_q[hrc_pkg::CTL_CLOCK_SOURCE_SELECT] ? osc_rise : xtal_tick);
   wire logic run = ctl_q[hrc_pkg::CTL_COUNTER_ENABLE];
   wire logic sec_tick = run & slow_tick & (prediv_q == 16'h0000);
   // Reload for the coming second: trim once in sixty-four, nominal otherwise
   wire logic [15:0] reload = ((sec64_q + 6'h01) == hrc_pkg::TRIM_SECOND) ?
                              trim_q : hrc_pkg::TRIM_NOMINAL;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xdiv_q <= 7'h00;
         prediv_q <= hrc_pkg::TRIM_NOMINAL;
         sec64_q <= 6'h00;
         count_q <= hrc_pkg::RST_COUNTER;
         count_moved_q <= 1'b0;
      end else begin
         if (xtal_rise) begin
            xdiv_q <= xdiv_q + 7'h01;
         end
         if (run && slow_tick) begin
            // A second lasts reload+1 slow ticks
            prediv_q <= sec_tick ? reload : prediv_q - 16'h0001;
         end
         if (sec_tick) begin
            sec64_q <= sec64_q + 6'h01;
         end
         if (we_ld) begin
            count_q <= ld_merged;
         end else if (sec_tick) begin
            count_q <= count_q + 32'h0000_0001;
         end
         count_moved_q <= we_ld | sec_tick;
      end
   end

   // ----------------------------------------------------------------
   // Matches, events and power state
   // ----------------------------------------------------------------
   // Compared once per counter change so a match flags once per arrival
   wire logic m0_hit = count_moved_q & (count_q == match0_q);
   wire logic m1_hit = count_moved_q & (count_q == match1_q);
   wire logic low_battery_flag_set = low_battery_flag_en & battery_low & ~in_hib;
   wire logic [3:0] ev_set = {wake_fall, low_battery_flag_set, m1_hit, m0_hit};
   // Set wins over a clear arriving in the same cycle
   wire logic [3:0] raw_d = (raw_q & ~clr_mask) | ev_set;

   always_comb begin
      wake_now = (ctl_q[hrc_pkg::CTL_PIN_WAKE_ENABLE] & wake_low) |
                 (ctl_q[hrc_pkg::CTL_MATCH_WAKE_ENABLE] & (m0_hit | m1_hit));
   end

   logic reg_off_n_q;
   logic irq_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         raw_q <= hrc_pkg::RST_EVENTS;
         state_q <= hrc_pkg::HRC_ST_RUN;
         reg_off_n_q <= 1'b1;
         irq_q <= 1'b0;
      end else begin
         raw_q <= raw_d;
         irq_q <= |(raw_q & mask_q);
         unique case (state_q)
            hrc_pkg::HRC_ST_RUN: begin
               if (hib_req && !abort_now) begin
                  state_q <= hrc_pkg::HRC_ST_HIB;
               end
            end
            hrc_pkg::HRC_ST_HIB: begin
               if (wake_now) begin
                  state_q <= hrc_pkg::HRC_ST_RUN;
               end
            end
         endcase
         reg_off_n_q <= ~in_hib;
      end
   end

   // ----------------------------------------------------------------
   // Bus read channel
   // ----------------------------------------------------------------
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   wire logic ar_take = axi_req.arvalid & arready_q;
   wire logic [11:0] rword = {axi_req.araddr[11:2], 2'b00};
   wire logic [11:0] rdata_off = rword - hrc_pkg::OFS_DATA_FIRST;
   wire logic rsel_data = (rword >= hrc_pkg::OFS_DATA_FIRST) &&
                          (rword <= hrc_pkg::OFS_DATA_LAST);
   wire logic [31:0] rd_reg =
      (rword == hrc_pkg::OFS_COUNTER) ? count_q :
      (rword == hrc_pkg::OFS_MATCH_ZERO) ? match0_q :
      (rword == hrc_pkg::OFS_MATCH_ONE) ? match1_q :
      (rword == hrc_pkg::OFS_LOAD) ? load_q :
      (rword == hrc_pkg::OFS_CONTROL) ? {24'h00_0000, ctl_q} :
      (rword == hrc_pkg::OFS_MASK) ? {28'h000_0000, mask_q} :
      (rword == hrc_pkg::OFS_RAW) ? {28'h000_0000, raw_q} :
      (rword == hrc_pkg::OFS_MASKED) ? {28'h000_0000, raw_q & mask_q} :
      (rword == hrc_pkg::OFS_TRIM) ? {16'h0000, trim_q} :
      rsel_data ? data_q[rdata_off[7:2]] : 32'h0000_0000;
   wire logic rmapped = rsel_data || (rword <= hrc_pkg::OFS_TRIM);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= hrc_pkg::RESP_OKAY;
      end else if (ar_take) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_reg;
         rresp_q <= rmapped ? hrc_pkg::RESP_OKAY : hrc_pkg::RESP_SLVERR;
      end else if (rvalid_q && axi_req.rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign axi_rsp.awready = awready_q;
   assign axi_rsp.wready = wready_q;
   assign axi_rsp.bvalid = bvalid_q;
   assign axi_rsp.bresp = bresp_q;
   assign axi_rsp.arready = arready_q;
   assign axi_rsp.rvalid = rvalid_q;
   assign axi_rsp.rdata = rdata_q;
   assign axi_rsp.rresp = rresp_q;
   assign regulator_off_n = reg_off_n_q;
   assign irq = irq_q;

endmodule
`default_nettype wire

// *** bench/hrc_far_side.sv ***
// Far-side model: regulator, wake button with pull-up, slow clock sources
`timescale 1ns/1ps
`default_nettype none
module hrc_far_side (
   // Power and wake
   input wire logic regulator_off_n,
   input wire logic wake_press,
   output logic wake_n,
   output var logic main_power,
   // Clock sources
   output var logic osc_32k_in,
   output var logic xtal_in
);
   // ---------------------------------------------
   // Sources run free, as the parts on the board do
   // ---------------------------------------------
   initial osc_32k_in = 1'b0;
   initial xtal_in = 1'b0;
   initial main_power = 1'b1;
   always #15258 osc_32k_in = ~osc_32k_in;
   always #119 xtal_in = ~xtal_in;
   // Pull-up holds the pin high once the button is let go
   assign wake_n = wake_press ? 1'b0 : 1'b1;
   // Rail settles a while after its enable moves
   always @(regulator_off_n) main_power <= #200 regulator_off_n;
endmodule
`default_nettype wire

// *** bench/hrc_assertions.sv ***
// Port checks on the hibernation power controller
`timescale 1ns/1ps
`default_nettype none
module hrc_assertions (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire hrc_pkg::hrc_axil_req_t axi_req,
   input wire hrc_pkg::hrc_axil_rsp_t axi_rsp,
   // Pins
   input wire logic osc_32k_in,
   input wire logic xtal_in,
   input wire logic wake_n,
   input wire logic low_battery_in,
   input wire logic regulator_off_n,
   input wire logic irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   bvalid_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready
      |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("bvalid dropped");
   rvalid_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready
      |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("rvalid dropped");
   read_latency_a: assert property (axi_req.arvalid && axi_rsp.arready
      |=> axi_rsp.rvalid && !axi_rsp.arready) else $error("read answer late");
   write_latency_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
      && axi_rsp.wready |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid) else $error("write late");
   write_block_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
      else $error("write taken early");
   write_release_a: assert property (axi_rsp.bvalid && axi_req.bready
      |=> !axi_rsp.bvalid && axi_rsp.awready) else $error("write not released");
   error_zero_a: assert property (axi_rsp.rvalid && axi_rsp.rresp == hrc_pkg::RESP_SLVERR
      |-> axi_rsp.rdata == 32'h0) else $error("error read not zero");
   reset_state_a: assert property ($rose(aresetn) |-> regulator_off_n && !irq)
      else $error("bad state after reset");
endmodule
bind hrc_controller hrc_assertions u_hrc_assertions (.aclk(aclk), .aresetn(aresetn),
   .axi_req(axi_req), .axi_rsp(axi_rsp), .osc_32k_in(osc_32k_in), .xtal_in(xtal_in),
   .wake_n(wake_n), .low_battery_in(low_battery_in), .regulator_off_n(regulator_off_n),
   .irq(irq));
`default_nettype wire

// *** bench/hrc_controller_test.sv ***
// Self-checking bench for the hibernation power controller
`timescale 1ns/1ps
`default_nettype none
module hrc_controller_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic low_bat = 1'b0;
   logic wake_press = 1'b0;
   logic [31:0] seed = 32'h5867B1E0;
   hrc_pkg::hrc_axil_req_t req = '0;
   hrc_pkg::hrc_axil_rsp_t rsp;
   logic osc, xtal, wake_n, reg_n, irq, main_power;
   logic [33:0] exp_q[$];
   int fails = 0;
   int n_checks = 0;
   always #12.5 aclk = ~aclk;
   hrc_controller u_hrc_controller (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
      .axi_rsp(rsp), .osc_32k_in(osc), .xtal_in(xtal), .wake_n(wake_n),
      .low_battery_in(low_bat), .regulator_off_n(reg_n), .irq(irq));
   hrc_far_side u_hrc_far_side (.regulator_off_n(reg_n), .wake_press(wake_press),
      .wake_n(wake_n), .main_power(main_power), .osc_32k_in(osc), .xtal_in(xtal));
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task chk(input logic [33:0] seen, input logic [33:0] want);
      n_checks++;
      if (seen !== want) begin
         fails++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task bit_chk(input logic seen, input logic want);
      chk({33'h0, seen}, {33'h0, want});
   endtask
   task tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task end_of_test;
      $display("Checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Write address and data offered together, each dropped once taken
   task wr(input logic [11:0] a, input logic [31:0] d);
      exp_q.push_back({hrc_pkg::RESP_OKAY, 32'h0});
      @(posedge aclk);
      req <= '{a, 1'b1, d, 4'hF, 1'b1, 1'b1, 12'h0, 1'b0, 1'b0};
      // No assumed latency; only the watchdog ends a hang
      do begin
         @(posedge aclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid);
      req.bready <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] r = hrc_pkg::RESP_OKAY);
      exp_q.push_back({r, d});
      @(posedge aclk);
      req <= '{12'h0, 1'b0, 32'h0, 4'h0, 1'b0, 1'b0, a, 1'b1, 1'b1};
      do begin
         @(posedge aclk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid);
      req.rready <= 1'b0;
   endtask
   // Answers are compared against the oldest note
   always @(posedge aclk) begin
      if (rsp.bvalid && req.bready) chk({rsp.bresp, 32'h0}, exp_q.pop_front());
      if (rsp.rvalid && req.rready) chk({rsp.rresp, rsp.rdata}, exp_q.pop_front());
   end
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   initial begin
      logic [31:0] v;
      logic [31:0] w[4];
      logic [11:0] a[4];
      tick(6);
      aresetn <= 1'b1;
      rd(hrc_pkg::OFS_MATCH_ONE, hrc_pkg::RST_MATCH);
      rd(hrc_pkg::OFS_TRIM, {16'h0, hrc_pkg::TRIM_NOMINAL});
      rd(hrc_pkg::OFS_COUNTER, 32'h0);
      rd(hrc_pkg::OFS_CONTROL, 32'h0);
      wr(hrc_pkg::OFS_CONTROL, 32'h44);
      rd(hrc_pkg::OFS_CONTROL, 32'h44);
      rd(12'h200, 32'h0, hrc_pkg::RESP_SLVERR);
      $display("Test reset values done");
      a = '{hrc_pkg::OFS_DATA_FIRST, 12'h034, 12'h0B0, hrc_pkg::OFS_DATA_LAST};
      foreach (a[k]) begin
         w[k] = rnd();
         wr(a[k], w[k]);
      end
      foreach (a[k]) rd(a[k], w[k]);
      $display("Test retained words done");
      v = rnd();
      wr(hrc_pkg::OFS_LOAD, v);
      rd(hrc_pkg::OFS_COUNTER, v);
      tick(20);
      rd(hrc_pkg::OFS_COUNTER, v);
      $display("Test load done");
      v = rnd();
      wr(hrc_pkg::OFS_MASK, 32'h1);
      wr(hrc_pkg::OFS_MATCH_ZERO, v);
      wr(hrc_pkg::OFS_MATCH_ONE, v);
      wr(hrc_pkg::OFS_LOAD, v);
      wr(hrc_pkg::OFS_CONTROL, 32'h41);
      tick(2);
      rd(hrc_pkg::OFS_RAW, 32'h3);
      bit_chk(irq, 1'b1);
      rd(hrc_pkg::OFS_MASKED, 32'h1);
      wr(hrc_pkg::OFS_RAW, 32'hF);
      wr(hrc_pkg::OFS_CLEAR, 32'h3);
      tick(2);
      rd(hrc_pkg::OFS_RAW, 32'h0);
      bit_chk(irq, 1'b0);
      $display("Test match events done");
      low_bat <= 1'b1;
      tick(8);
      wr(hrc_pkg::OFS_CONTROL, 32'hF6);
      tick(8);
      bit_chk(reg_n, 1'b1);
      rd(hrc_pkg::OFS_RAW, 32'h4);
      rd(hrc_pkg::OFS_CONTROL, 32'hF4);
      // Hibernating with the battery still low: no new flag while powered off
      wr(hrc_pkg::OFS_CONTROL, 32'h76);
      tick(8);
      wr(hrc_pkg::OFS_CLEAR, 32'h4);
      rd(hrc_pkg::OFS_RAW, 32'h0);
      low_bat <= 1'b0;
      $display("Test abort done");
      wr(hrc_pkg::OFS_CONTROL, 32'h56);
      tick(8);
      bit_chk(reg_n, 1'b0);
      wake_press <= 1'b1;
      tick(12);
      bit_chk(reg_n, 1'b1);
      wake_press <= 1'b0;
      rd(hrc_pkg::OFS_RAW, 32'h8);
      bit_chk(main_power, 1'b1);
      wr(hrc_pkg::OFS_CLEAR, 32'h8);
      $display("Test pin wake done");
      v = rnd();
      wr(hrc_pkg::OFS_MATCH_ZERO, v);
      wr(hrc_pkg::OFS_CONTROL, 32'h4F);
      tick(8);
      bit_chk(reg_n, 1'b0);
      wr(hrc_pkg::OFS_LOAD, v);
      tick(6);
      bit_chk(reg_n, 1'b1);
      rd(hrc_pkg::OFS_RAW, 32'h1);
      $display("Test match wake done");
      end_of_test();
   end
   initial begin
      #1500000;
      fails++;
      end_of_test();
   end
endmodule
`default_nettype wire
